/* core/adcseq_cfg.svh */
// constants for the converter control sequencer
`ifndef ADCSEQ_CFG_SVH
`define ADCSEQ_CFG_SVH

// host register offsets (3-bit address)
`define ADCSEQ_REG_CTRL 3'h0
`define ADCSEQ_REG_TSEL 3'h1
`define ADCSEQ_REG_MODE3 3'h2
`define ADCSEQ_REG_CHAN 3'h3
`define ADCSEQ_REG_CMPM 3'h4
`define ADCSEQ_REG_CMPT 3'h5
`define ADCSEQ_REG_CMD 3'h6
`define ADCSEQ_REG_STAT 3'h7

// host control fields
`define ADCSEQ_CTRL_TMD 0
`define ADCSEQ_CTRL_HS 1
`define ADCSEQ_CMD_APPLY 0
`define ADCSEQ_CMD_TRIG 1
`define ADCSEQ_CMD_STOP 2
`define ADCSEQ_CMD_CLRERR 3

// device register offsets on the device write port
`define ADCSEQ_DEV_M0 4'h0
`define ADCSEQ_DEV_M1 4'h1
`define ADCSEQ_DEV_M2 4'h2
`define ADCSEQ_DEV_CHAN 4'h3
`define ADCSEQ_DEV_CMPM 4'h4
`define ADCSEQ_DEV_CMPT 4'h5

// device field positions
`define ADCSEQ_M0_CE 7
`define ADCSEQ_M0_TMD 1
`define ADCSEQ_M1_HS 7
`define ADCSEQ_M1_TSEL_MASK 8'h07
`define ADCSEQ_M2_MASK 8'h03
`define ADCSEQ_CHAN_MASK 8'h0f

// legal conversion time select codes
`define ADCSEQ_TSEL_MIN 3'h0
`define ADCSEQ_TSEL_MAX 3'h5

// timing in converter clocks
`define ADCSEQ_STAB_CLKS 64
`define ADCSEQ_GAP_CLKS 65

// reset values
`define ADCSEQ_CTRL_RST 2'h0
`define ADCSEQ_TSEL_RST 3'h0

`endif

/* core/adcseq_pkg.sv */
// types of the converter control sequencer
package adcseq_pkg;
    typedef enum logic [1:0] {
        ADCSEQ_IDLE,
        ADCSEQ_WRITE,
        ADCSEQ_STAB,
        ADCSEQ_RUN
    } adcseq_state_t;
    typedef logic [2:0] adcseq_step_t;
endpackage

/* core/adcseq_gap_timer.sv */
// down counter that enforces spacing between device accesses
`timescale 1ns/10ps
module adcseq_gap_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    output logic done
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    generate
        // the enable wait loads 129, which needs eight bits
        if (WIDTH < 8) begin : g_bad_width
            $error("adcseq_gap_timer: WIDTH too small for 129 clocks");
        end
    endgenerate

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_val;
        end else if (count != '0) begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign done = (count == '0);
endmodule // adcseq_gap_timer

/* core/adcseq_ctrl.sv */
// host-side sequencer that programs and triggers the converter
//
// Functional notes
// - never change conversion-time select while convert enable is set.
// - clear convert enable before mode, channel or compare writes; re-enable.
// - external or timer trigger mode forces high-speed select to one.
// - no trigger during the stabilization after convert enable is set.
// - clear convert enable when the converter is not in use.
// - never touch the second mode register while convert enable is set.
// - reserved bits of second, third and channel registers written zero.
// - conversion-time code kept within the 2.6 to 10.4 us range.
// - triggers and control writes spaced more than 64 converter clocks.
// - high-speed mode: no writes or triggers during stabilization.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "adcseq_cfg.svh"
module adcseq_ctrl #(
    parameter int TIMER_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic ext_trig,
    output logic [3:0] dev_addr,
    output logic [7:0] dev_wdata,
    output logic dev_wr,
    output logic dev_trig,
    output logic dev_enabled
);
    import adcseq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // host registers

    logic [1:0] ctrl;
    logic [2:0] tsel;
    logic [7:0] mode3;
    logic [7:0] chan;
    logic [7:0] cmpm;
    logic [7:0] cmpt;
    logic cfg_error;
    logic [1:0] next_ctrl;
    logic [2:0] next_tsel;
    logic [7:0] next_mode3;
    logic [7:0] next_chan;
    logic [7:0] next_cmpm;
    logic [7:0] next_cmpt;
    logic next_cfg_error;
    logic [7:0] next_rdata;

    logic cmd_apply;
    logic cmd_trig;
    logic cmd_stop;
    logic tsel_ok;
    logic hs_eff;
    logic trig_req;

    adcseq_state_t state;
    adcseq_state_t next_state;
    adcseq_step_t step;
    adcseq_step_t next_step;
    logic stop_only;
    logic next_stop_only;
    logic ce;
    logic next_ce;
    logic trig_pend;
    logic next_trig_pend;
    logic [3:0] next_dev_addr;
    logic [7:0] next_dev_wdata;
    logic next_dev_wr;
    logic next_dev_trig;

    logic tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic tmr_done;

    function automatic logic is_cmd(input logic [2:0] a, input logic w);
        return w && (a == `ADCSEQ_REG_CMD);
    endfunction

    assign cmd_apply = is_cmd(addr, wr) && wdata[`ADCSEQ_CMD_APPLY];
    assign cmd_trig = is_cmd(addr, wr) && wdata[`ADCSEQ_CMD_TRIG];
    assign cmd_stop = is_cmd(addr, wr) && wdata[`ADCSEQ_CMD_STOP];
    assign tsel_ok = (tsel >= `ADCSEQ_TSEL_MIN) && (tsel <= `ADCSEQ_TSEL_MAX);
    assign hs_eff = ctrl[`ADCSEQ_CTRL_HS] | ctrl[`ADCSEQ_CTRL_TMD];
    // hardware trigger requests only mean something in trigger mode
    assign trig_req = ctrl[`ADCSEQ_CTRL_TMD] && (cmd_trig || ext_trig);

    generate
        if (TIMER_W < 8) begin : g_bad_timer_w
            $error("adcseq_ctrl: TIMER_W cannot hold the 129-clock wait");
        end
    endgenerate

    // config edits reach the device only through an apply sequence or, for the trigger mode bit, a stop write; the trigger mode bit gates triggers at once
    always_comb begin
        next_ctrl = ctrl;
        next_tsel = tsel;
        next_mode3 = mode3;
        next_chan = chan;
        next_cmpm = cmpm;
        next_cmpt = cmpt;
        next_cfg_error = cfg_error;
        next_rdata = 8'h00;
        if (wr) begin
            unique case (addr)
                `ADCSEQ_REG_CTRL: next_ctrl = wdata[1:0];
                `ADCSEQ_REG_TSEL: next_tsel = wdata[2:0];
                `ADCSEQ_REG_MODE3: next_mode3 = wdata;
                `ADCSEQ_REG_CHAN: next_chan = wdata;
                `ADCSEQ_REG_CMPM: next_cmpm = wdata;
                `ADCSEQ_REG_CMPT: next_cmpt = wdata;
                `ADCSEQ_REG_CMD: begin
                    if (wdata[`ADCSEQ_CMD_CLRERR]) begin
                        next_cfg_error = 1'b0;
                    end
                end
                `ADCSEQ_REG_STAT: ;
            endcase
        end
        // set wins over clear
        if (cmd_apply && !tsel_ok) begin
            next_cfg_error = 1'b1;
        end
        if (rd) begin
            unique case (addr)
                `ADCSEQ_REG_CTRL: next_rdata = {6'h00, ctrl};
                `ADCSEQ_REG_TSEL: next_rdata = {5'h00, tsel};
                `ADCSEQ_REG_MODE3: next_rdata = mode3;
                `ADCSEQ_REG_CHAN: next_rdata = chan;
                `ADCSEQ_REG_CMPM: next_rdata = cmpm;
                `ADCSEQ_REG_CMPT: next_rdata = cmpt;
                `ADCSEQ_REG_CMD: next_rdata = 8'h00;
                `ADCSEQ_REG_STAT: next_rdata = {3'h0, cfg_error, trig_pend,
                    state == ADCSEQ_STAB, ce, state == ADCSEQ_WRITE};
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `ADCSEQ_CTRL_RST;
            tsel <= `ADCSEQ_TSEL_RST;
            mode3 <= 8'h00;
            chan <= 8'h00;
            cmpm <= 8'h00;
            cmpt <= 8'h00;
            cfg_error <= 1'b0;
            rdata <= 8'h00;
        end else begin
            ctrl <= next_ctrl;
            tsel <= next_tsel;
            mode3 <= next_mode3;
            chan <= next_chan;
            cmpm <= next_cmpm;
            cmpt <= next_cmpt;
            cfg_error <= next_cfg_error;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // device write sequence

    // step order: disable, m1, m2, chan, cmp mode, cmp threshold, enable
    function automatic logic [11:0] dev_word(input logic [2:0] s,
                                             input logic en_bit);
        logic [7:0] m0;
        m0 = 8'h00;
        m0[`ADCSEQ_M0_CE] = en_bit;
        m0[`ADCSEQ_M0_TMD] = ctrl[`ADCSEQ_CTRL_TMD];
        unique case (s)
            3'h0: return {`ADCSEQ_DEV_M0, m0};
            3'h1: return {`ADCSEQ_DEV_M1, hs_eff, 4'h0, tsel};
            3'h2: return {`ADCSEQ_DEV_M2, mode3 & `ADCSEQ_M2_MASK};
            3'h3: return {`ADCSEQ_DEV_CHAN, chan & `ADCSEQ_CHAN_MASK};
            3'h4: return {`ADCSEQ_DEV_CMPM, cmpm};
            3'h5: return {`ADCSEQ_DEV_CMPT, cmpt};
            default: return {`ADCSEQ_DEV_M0, m0};
        endcase
    endfunction

    always_comb begin
        next_state = state;
        next_step = step;
        next_stop_only = stop_only;
        next_ce = ce;
        next_trig_pend = trig_pend;
        next_dev_addr = dev_addr;
        next_dev_wdata = dev_wdata;
        next_dev_wr = 1'b0;
        next_dev_trig = 1'b0;
        tmr_load = 1'b0;
        tmr_val = TIMER_W'(`ADCSEQ_GAP_CLKS);
        if (trig_req) begin
            next_trig_pend = 1'b1;
        end
        unique case (state)
            ADCSEQ_IDLE, ADCSEQ_RUN: begin
                // device restart is avoided by disabling first
                if (cmd_apply && tsel_ok) begin
                    next_state = ADCSEQ_WRITE;
                    next_step = 3'h0;
                    next_stop_only = 1'b0;
                    next_trig_pend = 1'b0;
                end else if (cmd_stop && ce) begin
                    next_state = ADCSEQ_WRITE;
                    next_step = 3'h0;
                    next_stop_only = 1'b1;
                    next_trig_pend = 1'b0;
                end else if (state == ADCSEQ_RUN && trig_pend && tmr_done) begin
                    next_dev_trig = 1'b1;
                    // a request in the firing cycle stays pending
                    next_trig_pend = trig_req;
                    tmr_load = 1'b1;
                end
            end
            ADCSEQ_WRITE: begin
                // pending triggers dropped while programming
                next_trig_pend = 1'b0;
                if (tmr_done) begin
                    {next_dev_addr, next_dev_wdata} = dev_word(step, step == 3'h6);
                    next_dev_wr = 1'b1;
                    tmr_load = 1'b1;
                    if (step == 3'h0) begin
                        next_ce = 1'b0;
                        if (stop_only) begin
                            next_state = ADCSEQ_IDLE;
                        end else begin
                            next_step = 3'h1;
                        end
                    end else if (step == 3'h6) begin
                        next_ce = 1'b1;
                        // past the 64-clock window so no collision at its end
                        tmr_val = TIMER_W'(`ADCSEQ_STAB_CLKS + `ADCSEQ_GAP_CLKS);
                        next_state = ADCSEQ_STAB;
                    end else begin
                        next_step = step + 3'h1;
                    end
                end
            end
            ADCSEQ_STAB: begin
                // triggers and apply or stop commands are dropped during stabilization
                next_trig_pend = 1'b0;
                if (tmr_done) begin
                    next_state = ADCSEQ_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ADCSEQ_IDLE;
            step <= 3'h0;
            stop_only <= 1'b0;
            ce <= 1'b0;
            trig_pend <= 1'b0;
            dev_addr <= 4'h0;
            dev_wdata <= 8'h00;
            dev_wr <= 1'b0;
            dev_trig <= 1'b0;
        end else begin
            state <= next_state;
            step <= next_step;
            stop_only <= next_stop_only;
            ce <= next_ce;
            trig_pend <= next_trig_pend;
            dev_addr <= next_dev_addr;
            dev_wdata <= next_dev_wdata;
            dev_wr <= next_dev_wr;
            dev_trig <= next_dev_trig;
        end
    end

    assign dev_enabled = ce;

    adcseq_gap_timer #(
        .WIDTH(TIMER_W)
    ) u_gap (
        .clock(clock),
        .rst_n(rst_n),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );
endmodule // adcseq_ctrl

/* verif/adcseq_ctrl_asserts.sv */
// port assertions for the converter control sequencer
`timescale 1ns/10ps
module adcseq_ctrl_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic [3:0] dev_addr,
    input wire logic [7:0] dev_wdata,
    input wire logic dev_wr,
    input wire logic dev_trig,
    input wire logic dev_enabled
);
    logic [7:0] gap, next_gap, age, next_age;
    logic hs, next_hs;
    wire acc = dev_wr | dev_trig;
    wire m0w = dev_wr && dev_addr == 4'h0;
    ////////////////////////////////////////
    // saturating ages so a long idle never wraps into a false failure
    always_comb begin
        next_gap = (gap == 8'hff) ? gap : gap + 8'h01;
        next_age = (age == 8'hff) ? age : age + 8'h01;
        next_hs = hs;
        if (acc) next_gap = 8'h00;
        if (m0w && dev_wdata[7]) next_age = 8'h00;
        if (dev_wr && dev_addr == 4'h1) next_hs = dev_wdata[7];
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 8'hff;
            age <= 8'hff;
            hs <= 1'b0;
        end else begin
            gap <= next_gap;
            age <= next_age;
            hs <= next_hs;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_gap; acc |-> gap >= 8'd65; endproperty
    a_gap: assert property (p_gap) else $error("access spacing short");
    property p_bit0; m0w |-> !dev_wdata[0]; endproperty
    a_bit0: assert property (p_bit0) else $error("mode bit0 set");
    property p_m1; dev_wr && dev_addr == 4'h1 |-> !dev_enabled; endproperty
    a_m1: assert property (p_m1) else $error("mode2 write enabled");
    property p_tsel;
        dev_wr && dev_addr == 4'h1 |-> dev_wdata[2:0] <= 3'h5;
    endproperty
    a_tsel: assert property (p_tsel) else $error("time code range");
    property p_dis; dev_wr && dev_addr > 4'h1 |-> !dev_enabled; endproperty
    a_dis: assert property (p_dis) else $error("write while enabled");
    property p_rsv;
        dev_wr |-> (dev_addr != 4'h1 || dev_wdata[6:3] == 4'h0)
            && (dev_addr != 4'h2 || dev_wdata[7:2] == 6'h00)
            && (dev_addr != 4'h3 || dev_wdata[7:4] == 4'h0);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_hs; m0w && dev_wdata[7] && dev_wdata[1] |-> hs; endproperty
    a_hs: assert property (p_hs) else $error("trigger mode w/o hs");
    property p_stab; dev_trig |-> dev_enabled && age >= 8'd129; endproperty
    a_stab: assert property (p_stab) else $error("trigger in stab");
    property p_stop;
        wr && addr == 3'h6 && wdata[2] && dev_enabled
            |-> ##[1:66] (m0w && !dev_wdata[7]);
    endproperty
    a_stop: assert property (p_stop) else $error("stop not sent");
    c_trig: cover property (dev_trig);
    c_en: cover property (m0w && dev_wdata[7]);
    c_stop: cover property (m0w && !dev_wdata[7] && $past(dev_enabled));
endmodule // adcseq_ctrl_asserts

/* verif/adcseq_dev_model.sv */
// behavioural converter seen from its register write port
`timescale 1ns/10ps
module adcseq_dev_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] dev_addr,
    input wire logic [7:0] dev_wdata,
    input wire logic dev_wr,
    input wire logic dev_trig,
    output int errs,
    output int convs
);
    logic [7:0] m0, m1;
    int stab, conv;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            m0 <= 8'h00;
            m1 <= 8'h00;
            stab <= 0;
            conv <= 0;
            errs <= 0;
            convs <= 0;
        end else begin
            if (stab > 0) stab <= stab - 1;
            if (conv > 0) conv <= conv - 1;
            if (dev_wr && dev_addr != 4'h0 && m0[7])
                errs <= errs + 1;
            if (dev_wr && dev_addr == 4'h0) begin
                m0 <= {dev_wdata[7:1], m0[0]};
                if (dev_wdata[7] && !m0[7]) stab <= 64;
            end
            if (dev_wr && dev_addr == 4'h1) m1 <= dev_wdata;
            if (dev_wr && conv > 0) conv <= m0[1] ? 0 : 40;
            if (stab == 1 && acc()) stab <= 64;
            if (dev_trig && (stab > 0 || !m0[7] || (m0[1] && !m1[7])))
                errs <= errs + 1;
            else if (dev_trig) begin
                conv <= 40;
                convs <= convs + 1;
            end
        end
    end
    function logic acc();
        return dev_wr | dev_trig;
    endfunction
endmodule // adcseq_dev_model

/* verif/tb_adcseq_ctrl.sv */
// self-checking bench for the converter control sequencer
`timescale 1ns/10ps
module tb_adcseq_ctrl;
    logic clock, rst_n, wr, rd, ext_trig, dev_wr, dev_trig, dev_enabled;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, s, dev_wdata;
    logic [3:0] dev_addr;
    logic [31:0] seed = 32, e;
    int errs, convs, miscompares, n_tests, cyc, trigs, exp_trig;
    int q[$];
    adcseq_ctrl dut (
        .clock(clock),
        .rst_n(rst_n),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .ext_trig(ext_trig),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_wr(dev_wr),
        .dev_trig(dev_trig),
        .dev_enabled(dev_enabled)
    );
    adcseq_dev_model dev (
        .clock(clock),
        .rst_n(rst_n),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_wr(dev_wr),
        .dev_trig(dev_trig),
        .errs(errs),
        .convs(convs)
    );
    ////////////////////////////////////////
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input logic [15:0] g, input logic [15:0] x);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task hw(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask
    task hr(input logic [2:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 s = rdata;
        @(posedge clock);
    endtask
    // pin then command trigger; both count only in trigger mode
    task trig();
        ext_trig <= 1'b1;
        @(posedge clock);
        ext_trig <= 1'b0;
        hw(3'h6, 8'h02);
    endtask
    task run_cfg(input logic tmd);
        logic [31:0] r;
        logic [7:0] v[6];
        for (int i = 0; i < 6; i++) begin
            r = xs();
            v[i] = r[7:0];
        end
        v[0] = {6'h0, v[0][1], tmd};
        v[1] = {5'h0, 3'(r % 6)};
        for (int i = 0; i < 6; i++) hw(3'(i), v[i]);
        hr(3'h1);
        chk(s, v[1]);
        q.push_back('h08300 | tmd << 1);
        q.push_back('h1ff00 | (v[0][1] | tmd) << 7 | v[1]);
        q.push_back('h2ff00 | v[2] & 3);
        q.push_back('h3ff00 | v[3] & 15);
        q.push_back('h4ff00 | v[4]);
        q.push_back('h5ff00 | v[5]);
        q.push_back('h08380 | tmd << 1);
        hw(3'h6, 8'h01);
        wait (dev_enabled === 1'b1);
        @(posedge clock);
        trig(); // dropped: still stabilizing
        do hr(3'h7); while (s[2] !== 1'b0);
        trig();
        exp_trig += tmd ? 2 : 0;
        repeat (131) @(posedge clock);
        chk(trigs, exp_trig);
        chk(convs, exp_trig);
        hw(3'h6, 8'h04);
        q.push_back('h08300 | tmd << 1);
        repeat (67) @(posedge clock);
        chk(dev_enabled, 1'b0);
        $display("test mode %0d done", tmd);
    endtask
    task stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    always @(posedge clock) begin
        cyc++;
        if (cyc > 6000) begin
            miscompares++;
            stop_test();
        end
        if (dev_trig) trigs++;
        if (dev_wr) begin
            e = q.size() ? q.pop_front() : 32'hfffff;
            chk({dev_addr, 4'h0, dev_wdata & e[15:8]}, {e[19:16], 4'h0, e[7:0]});
        end
    end
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        {wr, rd, ext_trig, addr, wdata} = '0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        hr(3'h1);
        chk(s, 8'h00);
        run_cfg(1'b1);
        run_cfg(1'b0);
        hw(3'h1, 8'h06);
        hw(3'h6, 8'h01);
        repeat (67) @(posedge clock);
        hr(3'h7);
        chk(s[4], 1'b1);
        hw(3'h6, 8'h08);
        hr(3'h7);
        chk(s[4], 1'b0);
        hr(3'h6);
        chk(s, 8'h00);
        chk(errs, 0);
        chk(q.size(), 0);
        $display("test refusal done");
        stop_test();
    end
endmodule // tb_adcseq_ctrl
bind adcseq_ctrl adcseq_ctrl_asserts u_chk (
    .clock(clock),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_wr(dev_wr),
    .dev_trig(dev_trig),
    .dev_enabled(dev_enabled)
);
